// ---- design/ahs_defines.svh ----
`ifndef AHS_DEFINES_SVH
`define AHS_DEFINES_SVH

// ==========================================================
// time bases and beep count
`define AHS_CLK_HZ 200000000
`define AHS_FILTER_HOURS 1000
`define AHS_RESTART_MIN 3
`define AHS_HOLD_MIN_S 3
`define AHS_HOLD_MAX_S 10
`define AHS_BLINK_S 5
`define AHS_CLEAN_MIN_RUN_MIN 10
`define AHS_CLEAN_RUN_MIN 20
`define AHS_ABORT_WIN_MIN 10
`define AHS_BEEPS 3

`endif

// ---- design/ahs_pkg.sv ----
package ahs_pkg;

  // ==========================================================
  // operating modes
  typedef enum logic [2:0] {
    AHS_MODE_COOL = 3'h0,
    AHS_MODE_DRY = 3'h1,
    AHS_MODE_AUTO_COOL = 3'h2,
    AHS_MODE_HEAT = 3'h3,
    AHS_MODE_AUTO_HEAT = 3'h4,
    AHS_MODE_FAN = 3'h5
  } ahs_mode_t;

  // ==========================================================
  // main sequencer states
  typedef enum logic [3:0] {
    AHS_ST_OFF = 4'b0001,
    AHS_ST_RUN = 4'b0010,
    AHS_ST_CLEAN = 4'b0100,
    AHS_ST_WAIT = 4'b1000
  } ahs_state_t;

  // user-side command strobes
  typedef struct packed {
    logic start;
    logic stop;
    logic filter;
  } ahs_cmd_t;

  // outputs to the unit
  typedef struct packed {
    logic run;
    logic filter_lamp;
    logic green;
    logic timer_lamp;
    logic beep;
    logic louver_slight;
    logic lowest_fan_speed;
    logic timer_clear;
  } ahs_out_t;

endpackage : ahs_pkg

// ---- design/ahs_tick.sv ----
`timescale 1ns/1ps
`include "ahs_defines.svh"

// ==========================================================
// second and minute enables from the system clock
module ahs_tick #(
  parameter int unsigned CYC_PER_SEC = `AHS_CLK_HZ
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic sec_en,
  output logic min_en
);

  typedef struct packed {
    logic [31:0] cyc;
    logic [5:0] sec;
    logic s_en;
    logic m_en;
  } ahs_tick_st_t;

  ahs_tick_st_t st_q;
  ahs_tick_st_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.s_en = 1'b0;
    st_d.m_en = 1'b0;
    if (st_q.cyc >= CYC_PER_SEC - 1) begin
      st_d.cyc = 32'h0000_0000;
      st_d.s_en = 1'b1;
      if (st_q.sec == 6'h3b) begin
        st_d.sec = 6'h00;
        st_d.m_en = 1'b1;
      end else begin
        st_d.sec = st_q.sec + 6'h01;
      end
    end else begin
      st_d.cyc = st_q.cyc + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sec_en = st_q.s_en;
  assign min_en = st_q.m_en;

endmodule : ahs_tick

// ---- design/ahs_seq.sv ----
`timescale 1ns/1ps
`include "ahs_defines.svh"
// Functional notes
// - lamp lights when filter hours reach one thousand.
// - button press or remote filter command turns lamp off.
// - button press with lamp dark starts automatic operation.
// - auto-restart resumes stored operation three minutes after power returns.
// - auto-restart is off after factory reset.
// - toggle gesture only while powered, button held three seconds.
// - hold must exceed three and stay under ten seconds.
// - from standby: start, green on, then triple beep, blink five seconds.
// - from running: stop, green off, then triple beep and blink.
// - repeating the gesture toggles auto-restart with same beeps.
// - auto-restart off: stay off after power return until start.
// - power failure discards programmed timer operation.
// - cool or dry stop enters self-clean, ends after its period.
// - under ten minutes no clean, otherwise twenty minutes.
// - never clean after heat, auto-heat or fan-only.
// - louver held slightly open during self-clean.
// - indoor fan at lowest speed during self-clean.
// - stop command starting self-clean lights only timer lamp.
// - two start/stop commands within ten minutes abort self-clean.
// - operation fully stops when self-clean completes.

module ahs_seq #(
  parameter int unsigned CYC_PER_SEC = `AHS_CLK_HZ,
  parameter int unsigned FILTER_HOURS = `AHS_FILTER_HOURS,
  parameter int unsigned MIN_PER_HOUR = 60
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic BUTTON,
  input wire logic POWER_RESTORED,
  input wire logic PURIFIER_ON,
  input wire logic TIMER_SET,
  input wire ahs_pkg::ahs_mode_t MODE,
  input wire ahs_pkg::ahs_cmd_t CMD,
  output ahs_pkg::ahs_out_t OUT,
  output logic AUTO_RESTART
);

  // ==========================================================
  // state
  typedef struct packed {
    logic btn_m;
    logic btn_s;
    logic btn_p;
    logic pwr_m;
    logic pwr_s;
    logic pwr_p;
    ahs_pkg::ahs_state_t st;
    ahs_pkg::ahs_mode_t mode;
    logic [3:0] hold_s;
    logic hold_long;
    logic auto_rs;
    logic rs_pend;
    logic [1:0] rs_min;
    logic [31:0] filt_min;
    logic lamp;
    logic [5:0] run_min;
    logic [4:0] clean_min;
    logic [3:0] abort_min;
    logic abort_arm;
    logic [2:0] ack_s;
    logic [2:0] beep_cnt;
    logic [2:0] blink_s;
    logic blink_ph;
    ahs_pkg::ahs_out_t o;
  } ahs_seq_st_t;

  ahs_seq_st_t s_q;
  ahs_seq_st_t s_d;
  logic sec_en;
  logic min_en;

  ahs_tick #(.CYC_PER_SEC(CYC_PER_SEC)) u_tick (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .sec_en(sec_en),
    .min_en(min_en)
  );

  // ==========================================================
  // mode classification, used in two places
  function automatic logic is_cool_dry(input ahs_pkg::ahs_mode_t m);
    is_cool_dry = (m == ahs_pkg::AHS_MODE_COOL) || (m == ahs_pkg::AHS_MODE_DRY) ||
                  (m == ahs_pkg::AHS_MODE_AUTO_COOL);
  endfunction : is_cool_dry

  logic btn_rise;
  logic btn_fall;
  logic pwr_rise;
  logic running;
  logic start_cmd;
  logic stop_cmd;

  always_comb begin
    s_d = s_q;
    btn_rise = s_q.btn_s && !s_q.btn_p;
    btn_fall = !s_q.btn_s && s_q.btn_p;
    pwr_rise = s_q.pwr_s && !s_q.pwr_p;
    running = (s_q.st == ahs_pkg::AHS_ST_RUN);
    start_cmd = CMD.start;
    stop_cmd = CMD.stop;
    // button and power-restore pins pass two flops before any logic
    s_d.btn_m = BUTTON;
    s_d.btn_s = s_q.btn_m;
    s_d.btn_p = s_q.btn_s;
    s_d.pwr_m = POWER_RESTORED;
    s_d.pwr_s = s_q.pwr_m;
    s_d.pwr_p = s_q.pwr_s;
    s_d.o.beep = 1'b0;
    s_d.o.timer_clear = 1'b0;

    // ==========================================================
    // filter service lamp
    // hour threshold
    if (PURIFIER_ON && min_en && !s_q.lamp) begin
      if (s_q.filt_min + 32'h0000_0001 >= FILTER_HOURS * MIN_PER_HOUR) begin
        s_d.lamp = 1'b1;
      end
      s_d.filt_min = s_q.filt_min + 32'h0000_0001;
    end
    if (CMD.filter || (btn_fall && !s_q.hold_long && s_q.lamp)) begin
      s_d.lamp = 1'b0;
      s_d.filt_min = 32'h0000_0000;
    end

    // ==========================================================
    // button hold timing
    if (btn_rise) begin
      s_d.hold_s = 4'h0;
      s_d.hold_long = 1'b0;
    end else if (s_q.btn_s && sec_en && s_q.hold_s != 4'hf) begin
      s_d.hold_s = s_q.hold_s + 4'h1;
      if (s_q.hold_s + 4'h1 == 4'(`AHS_HOLD_MIN_S)) begin
        s_d.hold_long = 1'b1;
      end
    end
    if (btn_fall && s_q.hold_long && s_q.hold_s < 4'(`AHS_HOLD_MAX_S)) begin
      s_d.auto_rs = !s_q.auto_rs;
      s_d.beep_cnt = 3'(`AHS_BEEPS);
      s_d.blink_s = 3'(`AHS_BLINK_S);
    end

    // ==========================================================
    // acknowledge beeps and blink
    if (sec_en && s_q.beep_cnt != 3'h0) begin
      s_d.o.beep = 1'b1;
      s_d.beep_cnt = s_q.beep_cnt - 3'h1;
    end
    if (sec_en && s_q.blink_s != 3'h0) begin
      s_d.blink_s = s_q.blink_s - 3'h1;
    end
    s_d.blink_ph = (s_q.blink_s != 3'h0) ? (sec_en ? !s_q.blink_ph : s_q.blink_ph) : 1'b0;

    // ==========================================================
    // power restore
    if (pwr_rise) begin
      s_d.o.timer_clear = TIMER_SET;
      s_d.st = ahs_pkg::AHS_ST_OFF;
      s_d.rs_pend = s_q.auto_rs;
      s_d.rs_min = 2'h0;
    end else if (s_q.rs_pend && min_en) begin
      if (s_q.rs_min + 2'h1 == 2'(`AHS_RESTART_MIN)) begin
        s_d.rs_pend = 1'b0;
        s_d.st = ahs_pkg::AHS_ST_RUN;
        s_d.run_min = 6'h00;
      end else begin
        s_d.rs_min = s_q.rs_min + 2'h1;
      end
    end

    // ==========================================================
    // main sequencer
    if (!pwr_rise) begin
      case (s_q.st)
        ahs_pkg::AHS_ST_OFF, ahs_pkg::AHS_ST_WAIT: begin
          if ((btn_rise && !s_q.lamp) || start_cmd) begin
            s_d.st = ahs_pkg::AHS_ST_RUN;
            s_d.mode = MODE;
            s_d.run_min = 6'h00;
            s_d.rs_pend = 1'b0;
          end
        end
        ahs_pkg::AHS_ST_RUN: begin
          s_d.mode = MODE;
          if (min_en && s_q.run_min != 6'h3f) begin
            s_d.run_min = s_q.run_min + 6'h01;
          end
          if (stop_cmd || (btn_rise && !s_q.lamp)) begin
            // cool or dry leads to clean
            if (is_cool_dry(s_q.mode) && s_q.run_min >= 6'(`AHS_CLEAN_MIN_RUN_MIN)) begin
              s_d.st = ahs_pkg::AHS_ST_CLEAN;
              s_d.clean_min = 5'h00;
              s_d.abort_arm = 1'b0;
            end else begin
              s_d.st = ahs_pkg::AHS_ST_OFF;
            end
          end
        end
        ahs_pkg::AHS_ST_CLEAN: begin
          if (min_en) begin
            s_d.clean_min = s_q.clean_min + 5'h01;
            s_d.abort_min = s_q.abort_min + 4'h1;
          end
          if (s_q.abort_arm && min_en && s_q.abort_min + 4'h1 >= 4'(`AHS_ABORT_WIN_MIN)) begin
            s_d.abort_arm = 1'b0;
          end
          if (min_en && s_q.clean_min + 5'h01 >= 5'(`AHS_CLEAN_RUN_MIN)) begin
            s_d.st = ahs_pkg::AHS_ST_OFF;
          end else if (start_cmd || stop_cmd) begin
            if (s_q.abort_arm) begin
              s_d.st = ahs_pkg::AHS_ST_OFF;
            end else begin
              s_d.abort_arm = 1'b1;
              s_d.abort_min = 4'h0;
            end
          end
        end
        default: begin
          s_d.st = ahs_pkg::AHS_ST_OFF;
        end
      endcase
    end

    // ==========================================================
    // output map
    s_d.o.run = (s_d.st == ahs_pkg::AHS_ST_RUN);
    s_d.o.green = (s_d.blink_s != 3'h0) ? s_d.blink_ph : s_d.o.run;
    s_d.o.timer_lamp = (s_d.st == ahs_pkg::AHS_ST_CLEAN) || (TIMER_SET && s_d.st != ahs_pkg::AHS_ST_CLEAN);
    s_d.o.louver_slight = (s_d.st == ahs_pkg::AHS_ST_CLEAN);
    s_d.o.lowest_fan_speed = (s_d.st == ahs_pkg::AHS_ST_CLEAN);
    s_d.o.filter_lamp = s_d.lamp;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      s_q <= '0;
      s_q.st <= ahs_pkg::AHS_ST_OFF;
      s_q.mode <= ahs_pkg::AHS_MODE_COOL;
      s_q.auto_rs <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign OUT = s_q.o;
  assign AUTO_RESTART = s_q.auto_rs;

  // ==========================================================
  // checks
  a_clean_louver_fan: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_q.st == ahs_pkg::AHS_ST_CLEAN |-> OUT.louver_slight && OUT.lowest_fan_speed && !OUT.run)
    else $error("clean outputs wrong");
  a_no_heat_clean: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_q.st == ahs_pkg::AHS_ST_RUN && !is_cool_dry(s_q.mode) |=> s_q.st != ahs_pkg::AHS_ST_CLEAN)
    else $error("clean after heat");
  a_short_run_skip: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_q.st == ahs_pkg::AHS_ST_RUN && s_q.run_min < 6'd10 |=> s_q.st != ahs_pkg::AHS_ST_CLEAN)
    else $error("clean after short run");
  a_lamp_clear_count: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CMD.filter |=> !s_q.lamp && s_q.filt_min == 32'h0000_0000)
    else $error("filter clear failed");
  a_restart_off_stay: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    pwr_rise && !s_q.auto_rs |=> !s_q.rs_pend)
    else $error("restart while disabled");
  a_timer_discard: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    pwr_rise && TIMER_SET |=> OUT.timer_clear)
    else $error("timer not discarded");
  a_clean_abort: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_q.st == ahs_pkg::AHS_ST_CLEAN && s_q.abort_arm && CMD.stop && !min_en && !pwr_rise
    |=> s_q.st == ahs_pkg::AHS_ST_OFF)
    else $error("abort ignored");
  a_gesture_toggle: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    btn_fall && s_q.hold_long && s_q.hold_s < 4'd10 |=> s_q.auto_rs != $past(s_q.auto_rs) && s_q.beep_cnt == 3'd3)
    else $error("gesture not toggled");

endmodule : ahs_seq

// ---- verification/ahs_user.sv ----
`timescale 1ns/1ps
// ==========================================================
// remote controller and front button user
module ahs_user (
  input wire logic clk,
  output logic button,
  output ahs_pkg::ahs_cmd_t cmd
);
  initial begin
    button = 1'b0;
    cmd = '0;
  end
  // level change just after an edge, held until the next call
  task automatic push(input logic lvl);
    @(posedge clk);
    #1 button = lvl;
  endtask : push
  // one-cycle strobe: 0 start, 1 stop, 2 filter
  task automatic send(input int which);
    @(posedge clk);
    #1 cmd = ahs_pkg::ahs_cmd_t'(3'h4 >> which);
    @(posedge clk);
    #1 cmd = '0;
    repeat (3) @(posedge clk);
  endtask : send
endmodule : ahs_user

// ---- verification/appliance_housekeeping_sequencer_bench.sv ----
`timescale 1ns/1ps
module appliance_housekeeping_sequencer_bench;
  // short time base keeps the run small: one second is five cycles
  localparam int SEC = 5;
  localparam int MIN = 60 * SEC;
  logic clk, rst_n, pr, purifier, timer_set, button, ar;
  ahs_pkg::ahs_mode_t mode;
  ahs_pkg::ahs_cmd_t cmd;
  ahs_pkg::ahs_out_t out;
  int n_fail = 0;
  int check_count = 0;
  int beep_n = 0;
  int clr_n = 0;
  int holds[5] = '{5, 5, 2, 11, 5};
  logic ar_exp[5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};

  ahs_seq #(.CYC_PER_SEC(SEC), .FILTER_HOURS(2), .MIN_PER_HOUR(1)) dut (
    .SYS_CLK(clk), .RST_N(rst_n), .BUTTON(button), .POWER_RESTORED(pr),
    .PURIFIER_ON(purifier), .TIMER_SET(timer_set), .MODE(mode), .CMD(cmd),
    .OUT(out), .AUTO_RESTART(ar)
  );
  ahs_user u_user (.clk(clk), .button(button), .cmd(cmd));

  // ==========================================================
  // helpers
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (out.beep === 1'b1) beep_n++;
    if (out.timer_clear === 1'b1) clr_n++;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic tally_and_finish();
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic press(input int s);
    u_user.push(1'b1);
    cyc(s * SEC);
    u_user.push(1'b0);
    cyc(SEC);
  endtask : press
  task automatic gesture(input int s, input logic run_exp, input logic ar_e);
    beep_n = 0;
    u_user.push(1'b1);
    cyc(SEC);
    chk(out.run, run_exp);
    chk(out.green, run_exp);
    cyc((s - 1) * SEC);
    u_user.push(1'b0);
    cyc(8 * SEC);
    chk(ar, ar_e);
    if (s == 5) chk(8'(beep_n), 8'h03);
    chk(out.run, run_exp);
  endtask : gesture
  task automatic power_cycle();
    clr_n = 0;
    pr = 1'b0;
    cyc(3);
    pr = 1'b1;
    cyc(10);
  endtask : power_cycle
  task automatic op(input ahs_pkg::ahs_mode_t m, input int mins);
    mode = m;
    u_user.send(0);
    cyc(mins * MIN);
    u_user.send(1);
    cyc(2);
  endtask : op

  // ==========================================================
  // watchdog, well past the expected span of the tests
  initial begin
    #400000;
    n_fail++;
    tally_and_finish();
  end

  // ==========================================================
  // tests
  initial begin
    rst_n = 1'b0;
    pr = 1'b1;
    purifier = 1'b0;
    timer_set = 1'b0;
    mode = ahs_pkg::AHS_MODE_FAN;
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    cyc(2);
    chk(out, 8'h00);
    chk(ar, 1'b0);
    purifier = 1'b1;
    cyc(3 * MIN / 2);
    chk(out.filter_lamp, 1'b0);
    cyc(MIN);
    chk(out.filter_lamp, 1'b1);
    purifier = 1'b0;
    press(1);
    chk(out.filter_lamp, 1'b0);
    chk(out.run, 1'b0);
    purifier = 1'b1;
    cyc(MIN);
    chk(out.filter_lamp, 1'b0);
    cyc(MIN);
    chk(out.filter_lamp, 1'b1);
    purifier = 1'b0;
    u_user.send(2);
    chk(out.filter_lamp, 1'b0);
    press(1);
    chk(out.run, 1'b1);
    u_user.send(1);
    chk(out.run, 1'b0);
    for (int i = 0; i < 5; i++) begin
      gesture(holds[i], (i % 2) == 0, ar_exp[i]);
    end
    timer_set = 1'b1;
    power_cycle();
    chk(8'(clr_n), 8'h01);
    timer_set = 1'b0;
    cyc(2 * MIN - 20);
    chk(out.run, 1'b0);
    cyc(MIN + 40);
    chk(out.run, 1'b1);
    u_user.send(1);
    gesture(5, 1'b1, 1'b0);
    power_cycle();
    cyc(7 * MIN / 2);
    chk(out.run, 1'b0);
    op(ahs_pkg::AHS_MODE_DRY, 8);
    op(ahs_pkg::AHS_MODE_DRY, 8);
    chk(out.louver_slight, 1'b0);
    op(ahs_pkg::AHS_MODE_HEAT, 11);
    chk(out, 8'h00);
    op(ahs_pkg::AHS_MODE_AUTO_HEAT, 11);
    chk(out, 8'h00);
    op(ahs_pkg::AHS_MODE_FAN, 11);
    chk(out, 8'h00);
    op(ahs_pkg::AHS_MODE_COOL, 11);
    chk(out.run, 1'b0);
    chk(out.louver_slight, 1'b1);
    chk(out.lowest_fan_speed, 1'b1);
    chk(out.timer_lamp, 1'b1);
    chk(out.green, 1'b0);
    cyc(18 * MIN);
    chk(out.louver_slight, 1'b1);
    chk(out.lowest_fan_speed, 1'b1);
    cyc(3 * MIN);
    chk(out, 8'h00);
    op(ahs_pkg::AHS_MODE_AUTO_COOL, 11);
    chk(out.louver_slight, 1'b1);
    u_user.send(1);
    cyc(MIN);
    u_user.send(1);
    chk(out, 8'h00);
    tally_and_finish();
  end
endmodule : appliance_housekeeping_sequencer_bench
